// File: sfh_host.sv
// Contract
// - All command, address and data bytes shift most significant bit first.
// - Dual address puts odd bits on lane one, even on lane zero.
// - Quad address sends four bits per clock, lane k holds bit k mod 4.
// - Program data carries one to 256 bytes, never more.
// - Security addresses use upper byte zero and a fixed page code.
// - Write enable precedes every program, erase and non-volatile status write.
// - Write enable is a lone 06h frame between chip select edges.
// - Volatile status writes are preceded by opcode 50h.
// - ABh with three dummy bytes wakes the part and returns its identifier.
// - 92h sends address and mode on two lanes, identifiers return on two.
// - 94h sends address and mode on four lanes, identifiers return on four.
// - 4Bh takes four dummy bytes then returns a 128 bit identifier.
`timescale 1ns/100ps
`default_nettype none
module sfh_host
    import sfh_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic [7:0]  cmd_opcode,
    input  wire logic [23:0] cmd_addr,
    input  wire logic [7:0]  cmd_mode,
    input  wire logic        cmd_addr_en,
    input  wire logic        cmd_mode_en,
    input  wire logic [1:0]  cmd_addr_lanes,
    input  wire logic [5:0]  cmd_dummy,
    input  wire logic [1:0]  cmd_data_lanes,
    input  wire logic        cmd_read,
    input  wire logic [8:0]  cmd_len,
    input  wire logic        cmd_volatile,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_valid,
    output logic             wr_ready,
    output logic      [7:0]  rd_data,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    output logic             done,
    output logic             refused,
    output logic             powered_down,
    output logic             flash_sclk,
    output logic             flash_cs_n,
    output logic      [3:0]  flash_lane_out,
    output logic      [3:0]  flash_lane_oe,
    input  wire logic [3:0]  flash_lane_in
);
    sfh_state_t  state_r;
    sfh_phase_t  phase_r;
    sfh_phase_t  nph;
    logic        pre_pend_r;
    logic [7:0]  f_op_r;
    logic [31:0] f_aw_r;
    logic [5:0]  f_abits_r;
    logic [1:0]  f_alanes_r;
    logic [5:0]  f_dummy_r;
    logic [1:0]  f_dlanes_r;
    logic        f_rd_r;
    logic [8:0]  f_len_r;
    logic [31:0] shr_r;
    logic [5:0]  clks_r;
    logic [1:0]  wid_r;
    logic [3:0]  div_r;
    logic [3:0]  gap_r;
    logic        sclk_r;
    logic        cs_n_r;
    logic [8:0]  bytes_r;
    logic [7:0]  rxb_r;
    logic        done_r;
    logic        refused_r;
    logic        pd_r;
    logic [3:0]  lane_out_r;
    logic [3:0]  lane_oe_r;
    logic [3:0]  in_s1_r;
    logic [3:0]  in_s2_r;
    logic [5:0]  d_abits;
    logic [1:0]  d_alanes;
    logic [5:0]  d_dummy;
    logic [1:0]  d_dlanes;
    logic        d_rd;
    logic        d_pre;
    logic [7:0]  d_pre_op;
    logic        d_err;
    logic        waiting;
    logic        data_go;
    logic        fall;
    logic        push;
    logic        buf_ready;
    logic        frame_end;

    ////////////////////////////////////////////////////////////////////////////////
    // Each opcode is forced into its fixed frame shape; others follow the descriptor.
    always_comb begin
        d_abits  = cmd_addr_en ? 6'((cmd_mode_en ? ADDR_CLKS_32 : ADDR_CLKS_24) >> cmd_addr_lanes)
                               : 6'h00;
        d_alanes = cmd_addr_lanes;
        d_dummy  = cmd_dummy;
        d_dlanes = cmd_data_lanes;
        d_rd     = cmd_read;
        d_pre    = 1'b0;
        d_pre_op = OP_WRITE_EN;
        d_err    = cmd_len > PROG_MAX;
        case (cmd_opcode)
            OP_WRITE_EN, OP_WRITE_DIS, OP_VOL_EN, OP_RST_ENABLE, OP_PWR_DOWN,
            OP_RST_DEVICE: begin
                d_abits = 6'h00;
                d_dummy = 6'h00;
                d_err   = cmd_len != 9'h000;
                d_pre   = cmd_opcode == OP_RST_DEVICE;
                d_pre_op = OP_RST_ENABLE;
            end
            OP_RD_STAT1, OP_RD_STAT2, OP_RD_STAT3, OP_PWR_UP_ID, OP_UNIQUE_ID: begin
                d_abits  = (cmd_opcode == OP_PWR_UP_ID && cmd_len != 9'h000) ? ADDR_CLKS_24
                                                                              : 6'h00;
                d_alanes = LANES_1;
                d_dummy  = (cmd_opcode == OP_UNIQUE_ID) ? UID_DUMMY : 6'h00;
                d_dlanes = LANES_1;
                d_rd     = 1'b1;
            end
            OP_WR_STAT1, OP_WR_STAT2, OP_WR_STAT3: begin
                d_abits  = 6'h00;
                d_dummy  = 6'h00;
                d_dlanes = LANES_1;
                d_rd     = 1'b0;
                d_err    = cmd_len == 9'h000 || cmd_len > ((cmd_opcode == OP_WR_STAT1) ? 9'h002
                                                                                      : 9'h001);
                d_pre    = 1'b1;
                d_pre_op = cmd_volatile ? OP_VOL_EN : OP_WRITE_EN;
            end
            OP_ID_DUAL, OP_ID_QUAD: begin
                d_alanes = (cmd_opcode == OP_ID_DUAL) ? LANES_2 : LANES_4;
                d_abits  = 6'(ADDR_CLKS_32 >> d_alanes);
                d_dummy  = (cmd_opcode == OP_ID_QUAD) ? QUAD_DUMMY : 6'h00;
                d_dlanes = d_alanes;
                d_rd     = 1'b1;
            end
            OP_PROG, OP_PROG_DUAL, OP_PROG_QUAD, OP_SEC_PROG: begin
                d_abits  = ADDR_CLKS_24;
                d_alanes = LANES_1;
                d_dummy  = 6'h00;
                d_dlanes = (cmd_opcode == OP_PROG_DUAL) ? LANES_2 :
                           (cmd_opcode == OP_PROG_QUAD) ? LANES_4 : LANES_1;
                d_rd     = 1'b0;
                d_err    = cmd_len == 9'h000 || cmd_len > PROG_MAX;
                d_pre    = 1'b1;
            end
            OP_PAGE_ER_A, OP_PAGE_ER_B, OP_SECT_ER, OP_BLK32_ER, OP_BLK64_ER, OP_SEC_ERASE,
            OP_CHIP_ER_A, OP_CHIP_ER_B: begin
                d_abits  = (cmd_opcode == OP_CHIP_ER_A || cmd_opcode == OP_CHIP_ER_B)
                           ? 6'h00 : ADDR_CLKS_24;
                d_alanes = LANES_1;
                d_dummy  = 6'h00;
                d_err    = cmd_len != 9'h000;
                d_pre    = 1'b1;
            end
            default: begin
            end
        endcase
        if ((cmd_opcode == OP_SEC_PROG || cmd_opcode == OP_SEC_ERASE || cmd_opcode == OP_SEC_READ)
            && (cmd_addr[23:16] != SEC_UPPER || (cmd_addr[15:9] != SEC_REG1
            && cmd_addr[15:9] != SEC_REG2 && cmd_addr[15:9] != SEC_REG3))) begin
            d_err = 1'b1;
        end
        if (pd_r && cmd_opcode != OP_PWR_UP_ID) begin
            d_err = 1'b1;
        end
    end

    always_comb begin
        case (phase_r)
            PH_CMD:   nph = pre_pend_r ? PH_END :
                            (f_abits_r != 6'h00) ? PH_ADDR :
                            (f_dummy_r != 6'h00) ? PH_DUMMY :
                            (f_len_r != 9'h000) ? PH_DATA : PH_END;
            PH_ADDR:  nph = (f_dummy_r != 6'h00) ? PH_DUMMY :
                            (f_len_r != 9'h000) ? PH_DATA : PH_END;
            PH_DUMMY: nph = (f_len_r != 9'h000) ? PH_DATA : PH_END;
            default:  nph = (bytes_r == 9'h001) ? PH_END : PH_DATA;
        endcase
    end

    // A full read buffer holds the serial clock low, so no byte is ever dropped.
    assign waiting   = state_r == ST_SHIFT && phase_r == PH_DATA && clks_r == 6'h00;
    assign data_go   = waiting && (f_rd_r ? buf_ready : wr_valid);
    assign wr_ready  = waiting && !f_rd_r && wr_valid;
    assign fall      = state_r == ST_SHIFT && !waiting && sclk_r && div_r == HALF_LAST;
    assign push      = fall && phase_r == PH_DATA && f_rd_r && clks_r == 6'h01;
    assign frame_end = state_r == ST_GAP && gap_r == GAP_LAST && !pre_pend_r;
    assign cmd_ready = state_r == ST_IDLE;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r    <= ST_IDLE;
            phase_r    <= PH_CMD;
            pre_pend_r <= 1'b0;
            f_op_r     <= 8'h00;
            f_aw_r     <= 32'h0000_0000;
            f_abits_r  <= 6'h00;
            f_alanes_r <= LANES_1;
            f_dummy_r  <= 6'h00;
            f_dlanes_r <= LANES_1;
            f_rd_r     <= 1'b0;
            f_len_r    <= 9'h000;
            shr_r      <= 32'h0000_0000;
            clks_r     <= 6'h00;
            wid_r      <= LANES_1;
            div_r      <= 4'h0;
            gap_r      <= 4'h0;
            sclk_r     <= 1'b0;
            cs_n_r     <= 1'b1;
            bytes_r    <= 9'h000;
            rxb_r      <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (cmd_valid && !d_err) begin
                        f_op_r     <= cmd_opcode;
                        f_aw_r     <= (cmd_opcode == OP_PWR_UP_ID) ? 32'h0000_0000
                                                                   : {cmd_addr, cmd_mode};
                        f_abits_r  <= d_abits;
                        f_alanes_r <= d_alanes;
                        f_dummy_r  <= d_dummy;
                        f_dlanes_r <= d_dlanes;
                        f_rd_r     <= d_rd;
                        f_len_r    <= cmd_len;
                        pre_pend_r <= d_pre;
                        shr_r      <= {(d_pre ? d_pre_op : cmd_opcode), 24'h00_0000};
                        cs_n_r     <= 1'b0;
                        phase_r    <= PH_CMD;
                        clks_r     <= BYTE_CLKS;
                        wid_r      <= LANES_1;
                        div_r      <= 4'h0;
                        state_r    <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (waiting) begin
                        if (data_go) begin
                            shr_r  <= {wr_data, 24'h00_0000};
                            clks_r <= 6'(BYTE_CLKS >> f_dlanes_r);
                            wid_r  <= f_dlanes_r;
                            div_r  <= 4'h0;
                        end
                    end else if (div_r != HALF_LAST) begin
                        div_r <= div_r + 4'h1;
                    end else begin
                        div_r  <= 4'h0;
                        sclk_r <= !sclk_r;
                        if (!sclk_r && phase_r == PH_DATA && f_rd_r) begin
                            case (f_dlanes_r)
                                LANES_2: rxb_r <= {rxb_r[5:0], flash_lane_in_s()};
                                LANES_4: rxb_r <= {rxb_r[3:0], in_s2_r};
                                default: rxb_r <= {rxb_r[6:0], in_s2_r[1]};
                            endcase
                        end
                        if (sclk_r) begin
                            if (clks_r > 6'h01) begin
                                clks_r <= clks_r - 6'h01;
                                case (wid_r)
                                    LANES_2: shr_r <= {shr_r[29:0], 2'h0};
                                    LANES_4: shr_r <= {shr_r[27:0], 4'h0};
                                    default: shr_r <= {shr_r[30:0], 1'h0};
                                endcase
                            end else begin
                                if (phase_r == PH_DATA) begin
                                    bytes_r <= bytes_r - 9'h001;
                                end
                                phase_r <= nph;
                                case (nph)
                                    PH_ADDR: begin
                                        shr_r  <= f_aw_r;
                                        clks_r <= f_abits_r;
                                        wid_r  <= f_alanes_r;
                                    end
                                    PH_DUMMY: clks_r <= f_dummy_r;
                                    PH_DATA: begin
                                        clks_r <= 6'h00;
                                        if (phase_r != PH_DATA) begin
                                            bytes_r <= f_len_r;
                                        end
                                    end
                                    default: state_r <= ST_TAIL;
                                endcase
                            end
                        end
                    end
                end
                ST_TAIL: begin
                    div_r <= div_r + 4'h1;
                    if (div_r == HALF_LAST) begin
                        cs_n_r  <= 1'b1;
                        gap_r   <= 4'h0;
                        state_r <= ST_GAP;
                    end
                end
                default: begin
                    gap_r <= gap_r + 4'h1;
                    if (gap_r == GAP_LAST) begin
                        if (pre_pend_r) begin
                            pre_pend_r <= 1'b0;
                            shr_r      <= {f_op_r, 24'h00_0000};
                            cs_n_r     <= 1'b0;
                            phase_r    <= PH_CMD;
                            clks_r     <= BYTE_CLKS;
                            wid_r      <= LANES_1;
                            div_r      <= 4'h0;
                            state_r    <= ST_SHIFT;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    function automatic logic [1:0] flash_lane_in_s();
        return in_s2_r[1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Dummy clocks and read data release every lane so the flash can drive them.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lane_out_r <= 4'h0;
            lane_oe_r  <= 4'h0;
        end else if (state_r == ST_SHIFT && (phase_r == PH_CMD || phase_r == PH_ADDR
                     || (phase_r == PH_DATA && !f_rd_r))) begin
            case (wid_r)
                LANES_2: begin
                    lane_out_r <= {2'h0, shr_r[31:30]};
                    lane_oe_r  <= 4'h3;
                end
                LANES_4: begin
                    lane_out_r <= shr_r[31:28];
                    lane_oe_r  <= 4'hF;
                end
                default: begin
                    lane_out_r <= {3'h0, shr_r[31]};
                    lane_oe_r  <= 4'h1;
                end
            endcase
        end else begin
            lane_out_r <= 4'h0;
            lane_oe_r  <= 4'h0;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            in_s1_r <= 4'h0;
            in_s2_r <= 4'h0;
        end else begin
            in_s1_r <= flash_lane_in;
            in_s2_r <= in_s1_r;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_r    <= 1'b0;
            refused_r <= 1'b0;
            pd_r      <= 1'b0;
        end else begin
            done_r    <= frame_end;
            refused_r <= cmd_ready && cmd_valid && d_err;
            if (frame_end && f_op_r == OP_PWR_DOWN) begin
                pd_r <= 1'b1;
            end else if (frame_end && f_op_r == OP_PWR_UP_ID) begin
                pd_r <= 1'b0;
            end
        end
    end

    // Reads stop after the requested count; the part would repeat forever.
    sfh_buf #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_rd_buf (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_data   (rxb_r),
        .in_valid  (push),
        .in_ready  (buf_ready),
        .out_data  (rd_data),
        .out_valid (rd_valid),
        .out_ready (rd_ready)
    );

    assign done           = done_r;
    assign refused        = refused_r;
    assign powered_down   = pd_r;
    assign flash_sclk     = sclk_r;
    assign flash_cs_n     = cs_n_r;
    assign flash_lane_out = lane_out_r;
    assign flash_lane_oe  = lane_oe_r;
endmodule
`default_nettype wire

// File: sfh_pkg.sv
package sfh_pkg;

    localparam int CLK_NS        = 10;
    localparam int SCLK_HALF_NS  = 40;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_HIGH_NS    = 50;
    localparam int CS_HIGH_CYC   = (CS_HIGH_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
    localparam logic [3:0] GAP_LAST  = 4'(CS_HIGH_CYC - 1);

    localparam logic [7:0] OP_WRITE_EN   = 8'h06;
    localparam logic [7:0] OP_WRITE_DIS  = 8'h04;
    localparam logic [7:0] OP_VOL_EN     = 8'h50;
    localparam logic [7:0] OP_WR_STAT1   = 8'h01;
    localparam logic [7:0] OP_WR_STAT2   = 8'h31;
    localparam logic [7:0] OP_WR_STAT3   = 8'h11;
    localparam logic [7:0] OP_RD_STAT1   = 8'h05;
    localparam logic [7:0] OP_RD_STAT2   = 8'h35;
    localparam logic [7:0] OP_RD_STAT3   = 8'h15;
    localparam logic [7:0] OP_PWR_DOWN   = 8'hB9;
    localparam logic [7:0] OP_PWR_UP_ID  = 8'hAB;
    localparam logic [7:0] OP_ID_DUAL    = 8'h92;
    localparam logic [7:0] OP_ID_QUAD    = 8'h94;
    localparam logic [7:0] OP_UNIQUE_ID  = 8'h4B;
    localparam logic [7:0] OP_RST_ENABLE = 8'h66;
    localparam logic [7:0] OP_RST_DEVICE = 8'h99;
    localparam logic [7:0] OP_PROG       = 8'h02;
    localparam logic [7:0] OP_PROG_DUAL  = 8'hA2;
    localparam logic [7:0] OP_PROG_QUAD  = 8'h32;
    localparam logic [7:0] OP_PAGE_ER_A  = 8'h81;
    localparam logic [7:0] OP_PAGE_ER_B  = 8'hDB;
    localparam logic [7:0] OP_SECT_ER    = 8'h20;
    localparam logic [7:0] OP_BLK32_ER   = 8'h52;
    localparam logic [7:0] OP_BLK64_ER   = 8'hD8;
    localparam logic [7:0] OP_CHIP_ER_A  = 8'hC7;
    localparam logic [7:0] OP_CHIP_ER_B  = 8'h60;
    localparam logic [7:0] OP_SEC_ERASE  = 8'h44;
    localparam logic [7:0] OP_SEC_PROG   = 8'h42;
    localparam logic [7:0] OP_SEC_READ   = 8'h48;

    localparam logic [1:0] LANES_1 = 2'h0;
    localparam logic [1:0] LANES_2 = 2'h1;
    localparam logic [1:0] LANES_4 = 2'h2;

    localparam logic [7:0] SEC_UPPER = 8'h00;
    localparam logic [6:0] SEC_REG1  = 7'h08;
    localparam logic [6:0] SEC_REG2  = 7'h10;
    localparam logic [6:0] SEC_REG3  = 7'h18;
    localparam logic [8:0] PROG_MAX  = 9'h100;

    localparam logic [5:0] ADDR_CLKS_24 = 6'h18;
    localparam logic [5:0] ADDR_CLKS_32 = 6'h20;
    localparam logic [5:0] BYTE_CLKS    = 6'h08;
    localparam logic [5:0] QUAD_DUMMY   = 6'h04;
    localparam logic [5:0] UID_DUMMY    = 6'h20;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL, ST_GAP} sfh_state_t;
    typedef enum logic [2:0] {PH_CMD, PH_ADDR, PH_DUMMY, PH_DATA, PH_END} sfh_phase_t;

endpackage

// File: sfh_buf.sv
`timescale 1ns/100ps
`default_nettype none
module sfh_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0]      wr_ptr_r;
    logic [AW:0]      rd_ptr_r;

    // The extra pointer bit tells a full buffer from an empty one.
    assign in_ready  = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
    assign out_valid = wr_ptr_r != rd_ptr_r;
    assign out_data  = mem_r[rd_ptr_r[AW-1:0]];

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_r <= '0;
        end else if (in_valid && in_ready) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (in_valid && in_ready) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_ptr_r <= '0;
        end else if (out_valid && out_ready) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: sfh_host_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sfh_host_chk (
    input wire logic       mclk,
    input wire logic       rstn,
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic [7:0] cmd_opcode,
    input wire logic [8:0] cmd_len,
    input wire logic       done,
    input wire logic       refused,
    input wire logic       powered_down,
    input wire logic       flash_sclk,
    input wire logic       flash_cs_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire logic acc = cmd_valid && cmd_ready;
    chk_idle_cs_high: assert property (cmd_ready |-> flash_cs_n) else $error("cs low idle");
    chk_sclk_idle: assert property (flash_cs_n |-> !flash_sclk) else $error("sclk moved");
    chk_sclk_half: assert property ($rose(flash_sclk) |-> flash_sclk[*4] ##1 !flash_sclk)
        else $error("sclk high time");
    chk_done_ready: assert property (done |-> cmd_ready) else $error("done while busy");
    chk_refuse_quiet: assert property (refused |-> flash_cs_n && !done) else $error("pins");
    chk_sleep_refuse: assert property (acc && powered_down && cmd_opcode != 8'hAB |=> refused)
        else $error("sleep not refused");
    chk_len_refuse: assert property (acc && cmd_len > 9'h100 |=> refused) else $error("len");
    chk_prog_empty: assert property (acc && cmd_opcode == 8'h02 && cmd_len == 9'h000 |=> refused)
        else $error("empty program");
endmodule
bind sfh_host sfh_host_chk chk_u (.*);
`default_nettype wire

// File: sfh_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module sfh_flash_model (
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic si,
    output logic      so
);
    logic [7:0] op_r = 8'h00;
    logic [3:0] cnt_r = 4'h0;
    logic [2:0] bit_r = 3'h0;
    logic       wel_r = 1'h0;
    logic       arm_r = 1'h0;
    // Only a frame of exactly eight clocks acts; 50h falls through untouched.
    // Self-timed work is not modelled, so the latch stays set until 04h or a reset.
    always @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            cnt_r <= 4'h0;
            if (cnt_r == 4'h8 && op_r == 8'h06) wel_r <= 1'h1;
            arm_r <= cnt_r == 4'h8 && op_r == 8'h66;
            if (cnt_r == 4'h8 && (op_r == 8'h04 || (op_r == 8'h99 && arm_r))) begin
                wel_r <= 1'h0;
            end
        end else if (cnt_r < 4'h8) begin
            op_r <= {op_r[6:0], si};
            cnt_r <= cnt_r + 4'h1;
        end else begin
            cnt_r <= 4'h9;
        end
    end
    // A released line shows the inverse of its last level, so a late sample cannot pass by luck.
    always @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_r <= 3'h0;
            so <= ~so;
        end else if (cnt_r >= 4'h8) begin
            so <= (bit_r == 3'h6) && wel_r;
            bit_r <= bit_r + 3'h1;
        end
    end
endmodule
`default_nettype wire

// File: sfh_host_bench.sv
`timescale 1ns/100ps
`default_nettype none
module sfh_host_bench
    import sfh_pkg::*;
;
    // Write data is always on offer, so each data byte is taken in the cycle it is asked for.
    logic        mclk = 1'h0, rstn = 1'h0, cmd_valid = 1'h0, wr_valid = 1'h1, rd_ready = 1'h1;
    logic        cmd_addr_en, cmd_mode_en, cmd_read, cmd_volatile, so;
    logic        cmd_ready, wr_ready, rd_valid, done, refused, powered_down, flash_sclk, flash_cs_n;
    logic [7:0]  cmd_opcode = 8'h00, cmd_mode, wr_data, rd_data;
    logic [23:0] cmd_addr;
    logic [5:0]  cmd_dummy;
    logic [1:0]  cmd_addr_lanes, cmd_data_lanes;
    logic [8:0]  cmd_len = 9'h000;
    logic [3:0]  flash_lane_out, flash_lane_oe, flash_lane_in;
    logic [7:0]  exp_q[$];
    int          n_errors = 0, n_tests = 0, n_wr = 0;
    always #5 mclk = ~mclk;
    assign flash_lane_in = (flash_lane_oe & flash_lane_out) | (~flash_lane_oe & {2'h3, so, 1'h1});
    sfh_host dut_u (.*);
    sfh_flash_model flash_u (.sclk(flash_sclk), .cs_n(flash_cs_n), .si(flash_lane_in[0]), .so(so));
    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] want);
        n_tests++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic scramble;
        {cmd_addr, cmd_mode, cmd_addr_en, cmd_mode_en, cmd_dummy, cmd_read, cmd_volatile,
            wr_data} = 50'({$urandom, $urandom});
        cmd_addr_lanes = 2'($urandom % 3);
        cmd_data_lanes = 2'($urandom % 3);
    endtask
    task automatic run(input logic [7:0] op, input logic [8:0] len, input logic rf);
        int i;
        scramble;
        cmd_opcode = op;
        cmd_len = len;
        cmd_valid = 1'h1;
        @(posedge mclk) #1;
        cmd_valid = 1'h0;
        for (i = 0; i < 9000 && !(done || refused); i++) @(posedge mclk) #1;
        check("outcome", {7'h00, refused, done}, {7'h00, rf, ~rf});
        @(posedge mclk) #1;
    endtask
    task automatic rd_stat(input logic [8:0] len, input logic [7:0] val);
        repeat (len) exp_q.push_back(val);
        run(OP_RD_STAT1, len, 1'h0);
    endtask
    // Random back-pressure delays each pop a few cycles; a byte takes 64, so the two-entry buffer never fills or stalls the clock.
    always @(posedge mclk) #1 rd_ready = 1'($urandom);
    always @(negedge mclk) if (wr_ready === 1'h1) n_wr++;
    always @(negedge mclk) begin
        if (rd_valid === 1'h1 && rd_ready) begin
            check("byte", {1'h0, rd_data}, exp_q.size() ? {1'h0, exp_q.pop_front()} : 9'h1FF);
        end
    end
    initial begin
        void'($urandom(47051));
        scramble;
        repeat (12) @(posedge mclk);
        #1 rstn = 1'h1;
        rd_stat(9'h002, 8'h00);
        run(OP_WRITE_EN, 9'h000, 1'h0);
        rd_stat(9'h003, 8'h02);
        run(OP_VOL_EN, 9'h000, 1'h0);
        rd_stat(9'h001, 8'h02);
        run(OP_WRITE_DIS, 9'h000, 1'h0);
        rd_stat(9'h001, 8'h00);
        run(OP_SECT_ER, 9'h000, 1'h0);
        rd_stat(9'h001, 8'h02);
        run(OP_RST_DEVICE, 9'h000, 1'h0);
        rd_stat(9'h001, 8'h00);
        run(OP_WR_STAT1, 9'h002, 1'h0);
        check("taken", 9'(n_wr), 9'h002);
        rd_stat(9'h001, cmd_volatile ? 8'h00 : 8'h02);
        run(OP_PROG, 9'h000, 1'h1);
        run(OP_RD_STAT1, 9'h101, 1'h1);
        run(OP_PWR_DOWN, 9'h000, 1'h0);
        check("sleep", {8'h00, powered_down}, 9'h001);
        run(OP_RD_STAT1, 9'h001, 1'h1);
        run(OP_PWR_UP_ID, 9'h000, 1'h0);
        check("sleep", {8'h00, powered_down}, 9'h000);
        repeat (200) @(posedge mclk);
        check("left", 9'(exp_q.size()), 9'h000);
        finish_test;
    end
    initial begin
        #200000;
        n_errors++;
        finish_test;
    end
endmodule
`default_nettype wire
